// File: bdc_pkg.sv
/*
 * Constants for the background debug command executor: command codes,
 * system register select codes, responses, sizes and machine states.
 * Assumes the serial shifter outside takes 16-bit words from the host and returns 17-bit words.
 */
`default_nettype none

package bdc_pkg;
    // System register select codes
    localparam logic [3:0] SEL_RPC  = 4'h0;
    localparam logic [3:0] SEL_PCC  = 4'h1;
    localparam logic [3:0] SEL_TEMP = 4'h8;
    localparam logic [3:0] SEL_FAR  = 4'h9;
    localparam logic [3:0] SEL_VBR  = 4'hA;
    localparam logic [3:0] SEL_SR   = 4'hB;
    localparam logic [3:0] SEL_USP  = 4'hC;
    localparam logic [3:0] SEL_SSP  = 4'hD;
    localparam logic [3:0] SEL_SFC  = 4'hE;
    localparam logic [3:0] SEL_DFC  = 4'hF;
    // Command codes
    localparam logic [11:0] OPC_SYSREG_WRITE_CMD = 12'h248;
    localparam logic [7:0]  OPC_READ  = 8'h19;
    localparam logic [7:0]  OPC_WRITE = 8'h18;
    localparam logic [7:0]  OPC_DUMP  = 8'h1D;
    localparam logic [7:0]  OPC_FILL  = 8'h1C;
    localparam logic [15:0] OPC_CALL  = 16'h0800;
    localparam logic [15:0] OPC_GO    = 16'h0C00;
    localparam logic [15:0] OPC_NOP   = 16'h0000;
    // Responses
    localparam logic [16:0] RSP_DONE  = 17'h0FFFF;
    localparam logic [16:0] RSP_NRDY  = 17'h10000;
    localparam logic [16:0] RSP_ERR   = 17'h10001;
    localparam logic [16:0] RSP_ILL   = 17'h1FFFF;
    // Operand sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    // Supervisor bit of the status word, push spaces
    localparam int         SR_SUPER_BIT = 13;
    localparam logic [2:0] FC_SUP_DATA  = 3'h5;
    localparam logic [2:0] FC_USR_DATA  = 3'h1;
    localparam logic [31:0] PUSH_STEP   = 32'h4;
    // Command classes
    typedef enum logic [3:0] {
        CLS_ILL, CLS_NOP, CLS_SYSREG_WRITE_CMD, CLS_READ, CLS_WRITE,
        CLS_DUMP, CLS_FILL, CLS_GO, CLS_CALL
    } bdc_cls_e;
    typedef enum logic [5:0] {
        ST_RUN  = 6'h01,
        ST_IDLE = 6'h02,
        ST_OPND = 6'h04,
        ST_MEM  = 6'h08,
        ST_RES  = 6'h10,
        ST_PF   = 6'h20
    } bdc_state_e;
endpackage

`default_nettype wire

// File: bdc_executor.sv
/*
 * Background debug command executor: decodes words from the serial
 * shifter, runs system register, memory, block and resume commands.
 * Assumes rx_valid pulses once per completed transfer and that
 * tx_word is sampled by the shifter at the start of each transfer.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Codes 0,1,B,C,D pick RETURN_PROG_COUNTER-class registers
// - Codes E,F,8,9,A pick remaining registers
// - Narrow register writes keep low word
// - Register write answers command complete
// - Fault address register ignores writes
// - Read uses source space, three sizes
// - Byte zero-extended, word 16, long 32
// - Read ok clears bit 16; error 10001
// - Write uses destination space, three sizes
// - Write ok 0FFFF; error 10001
// - Read and dump advance saved pointer
// - Dump answers like read
// - Write and fill advance saved pointer
// - Fill takes one data operand
// - Resume restarts at return counter
// - First prefetch fault raises exception
// - Call pushes return, jumps to operand
// - Push fault answers error, stays halted
// - Long results go high word first
// - Transfers during access get not-ready
// - Unknown opcodes answer illegal
module bdc_executor
    import bdc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        rx_valid,
    input  wire logic [15:0] rx_word,
    output logic      [16:0] tx_word,
    input  wire logic        enter_debug,
    output logic             debug_mode,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [2:0]  mem_fc,
    output logic      [1:0]  mem_size,
    output logic      [31:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic        mem_err,
    input  wire logic [31:0] mem_rdata,
    output logic             pc_load,
    output logic      [31:0] new_pc,
    input  wire logic        pf_done,
    input  wire logic        pf_err,
    input  wire logic        pf_addr_err,
    output logic             exc_req,
    output logic      [31:0] status_word
);
    import bdc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // opcode decode
    function automatic bdc_cls_e cls_of(input logic [15:0] c);
        if (c[15:4] == OPC_SYSREG_WRITE_CMD) return CLS_SYSREG_WRITE_CMD;
        if (c[5:0] == 6'h00 && c[15:8] == OPC_READ) return CLS_READ;
        if (c[5:0] == 6'h00 && c[15:8] == OPC_WRITE) return CLS_WRITE;
        if (c[5:0] == 6'h00 && c[15:8] == OPC_DUMP) return CLS_DUMP;
        if (c[5:0] == 6'h00 && c[15:8] == OPC_FILL) return CLS_FILL;
        if (c == OPC_CALL) return CLS_CALL;
        if (c == OPC_GO) return CLS_GO;
        if (c == OPC_NOP) return CLS_NOP;
        return CLS_ILL;
    endfunction

    function automatic logic [31:0] inc_of(input logic [1:0] sz);
        return (sz == SZ_BYTE) ? 32'h1 : (sz == SZ_WORD) ? 32'h2 : 32'h4;
    endfunction

    // Operand words: one longword, address then data, data only
    function automatic logic [2:0] words_of(input bdc_cls_e k, input logic [1:0] sz);
        logic [2:0] dw;
        dw = (sz == SZ_BYTE || sz == SZ_WORD) ? 3'h1 : 3'h2;
        unique case (k)
            CLS_SYSREG_WRITE_CMD, CLS_READ, CLS_CALL: return 3'h2;
            CLS_WRITE: return 3'h2 + dw;
            CLS_FILL:  return dw;
            default:   return 3'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    bdc_state_e  state_reg, state_next;
    logic [15:0] cmd_reg, cmd_next;
    logic [2:0]  idx_reg, idx_next;
    logic [31:0] addr_reg, addr_next;
    logic [31:0] data_reg, data_next;
    logic [31:0] ptr_reg, ptr_next;
    logic [15:0] lo_reg, lo_next;
    logic [16:0] tx_reg, tx_next;
    logic        dbg_reg, dbg_next;
    logic        req_reg, req_next;
    logic        we_reg, we_next;
    logic [31:0] maddr_reg, maddr_next;
    logic [2:0]  fc_reg, fc_next;
    logic [1:0]  sz_reg, sz_next;
    logic [31:0] wd_reg, wd_next;
    logic        pcl_reg, pcl_next;
    logic [31:0] npc_reg, npc_next;
    logic        exc_reg, exc_next;
    logic [31:0] sreg_reg [16];
    logic [31:0] sreg_next [16];

    logic [15:0] cmd_v;
    bdc_cls_e    cls_v;
    logic        exec_now;
    logic [31:0] addr_v, data_v, inc_v;
    logic [3:0]  sp_sel;

    always_comb begin
        state_next = state_reg;
        cmd_next   = cmd_reg;
        idx_next   = idx_reg;
        addr_next  = addr_reg;
        data_next  = data_reg;
        ptr_next   = ptr_reg;
        lo_next    = lo_reg;
        tx_next    = tx_reg;
        dbg_next   = dbg_reg;
        req_next   = req_reg;
        we_next    = we_reg;
        maddr_next = maddr_reg;
        fc_next    = fc_reg;
        sz_next    = sz_reg;
        wd_next    = wd_reg;
        pcl_next   = 1'b0;
        npc_next   = npc_reg;
        exc_next   = 1'b0;
        sreg_next  = sreg_reg;
        exec_now   = 1'b0;
        cmd_v      = (state_reg == ST_IDLE) ? rx_word : cmd_reg;
        cls_v      = cls_of(cmd_v);
        inc_v      = inc_of(cmd_v[7:6]);
        addr_v     = addr_reg;
        data_v     = data_reg;
        sp_sel     = sreg_reg[SEL_SR][SR_SUPER_BIT] ? SEL_SSP : SEL_USP;

        unique case (state_reg)
            ST_RUN: begin
                if (enter_debug) begin
                    dbg_next   = 1'b1;
                    tx_next    = RSP_DONE;
                    state_next = ST_IDLE;
                end
            end
            ST_PF: begin
                // fault on first prefetch becomes a normal exception
                if (pf_done) begin
                    state_next = ST_RUN;
                    exc_next   = pf_err;
                    if (pf_err && pf_addr_err)
                        sreg_next[SEL_FAR] = sreg_reg[SEL_RPC];
                end
            end
            ST_IDLE: begin
                if (rx_valid) begin
                    cmd_next = rx_word;
                    idx_next = 3'h0;
                    // unknown opcode acts as null, answers illegal
                    if (cls_v == CLS_ILL)
                        tx_next = RSP_ILL;
                    else if (words_of(cls_v, rx_word[7:6]) == 3'h0)
                        exec_now = 1'b1;
                    else begin
                        tx_next    = RSP_NRDY;
                        state_next = ST_OPND;
                    end
                end
            end
            ST_OPND: begin
                if (rx_valid) begin
                    // address words come first, data words after
                    if ((cls_v == CLS_READ || cls_v == CLS_WRITE) && idx_reg < 3'h2)
                        addr_v = {addr_reg[15:0], rx_word};
                    else
                        data_v = {data_reg[15:0], rx_word};
                    addr_next = addr_v;
                    data_next = data_v;
                    idx_next  = idx_reg + 3'h1;
                    if (idx_reg + 3'h1 == words_of(cls_v, cmd_reg[7:6]))
                        exec_now = 1'b1;
                end
            end
            ST_MEM: begin
                // tx stays not-ready while the access runs
                if (mem_ack) begin
                    req_next   = 1'b0;
                    state_next = ST_IDLE;
                    unique case (cls_v)
                        CLS_READ, CLS_DUMP: begin
                            // pointer advances by size, fault or not
                            ptr_next = maddr_reg + inc_v;
                            if (mem_err)
                                tx_next = RSP_ERR;
                            else begin
                                unique case (sz_reg)
                                    SZ_BYTE: tx_next = {9'h000, mem_rdata[7:0]};
                                    SZ_WORD: tx_next = {1'b0, mem_rdata[15:0]};
                                    default: begin
                                        tx_next    = {1'b0, mem_rdata[31:16]};
                                        lo_next    = mem_rdata[15:0];
                                        state_next = ST_RES;
                                    end
                                endcase
                            end
                        end
                        CLS_WRITE, CLS_FILL: begin
                            tx_next  = mem_err ? RSP_ERR : RSP_DONE;
                            ptr_next = maddr_reg + inc_v;
                        end
                        default: begin
                            if (mem_err)
                                tx_next = RSP_ERR;
                            else begin
                                // load operand as pc and leave
                                sreg_next[sp_sel]  = maddr_reg;
                                sreg_next[SEL_RPC] = data_reg;
                                npc_next   = data_reg;
                                pcl_next   = 1'b1;
                                dbg_next   = 1'b0;
                                state_next = ST_PF;
                            end
                        end
                    endcase
                end
            end
            ST_RES: begin
                if (rx_valid) begin
                    tx_next    = {1'b0, lo_reg};
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_RUN;
        endcase

        if (exec_now) begin
            tx_next    = RSP_NRDY;
            state_next = ST_IDLE;
            sz_next    = cmd_v[7:6];
            unique case (cls_v)
                CLS_SYSREG_WRITE_CMD: begin
                    // fault address writes dropped; narrow low word
                    if (cmd_v[3:0] == SEL_SR || cmd_v[3:0] == SEL_SFC
                        || cmd_v[3:0] == SEL_DFC)
                        sreg_next[cmd_v[3:0]] = {16'h0000, data_v[15:0]};
                    else if (cmd_v[3:0] != SEL_FAR)
                        sreg_next[cmd_v[3:0]] = data_v;
                    tx_next = RSP_DONE;
                end
                CLS_READ, CLS_DUMP, CLS_WRITE, CLS_FILL: begin
                    // absolute address, space from function codes
                    req_next   = 1'b1;
                    state_next = ST_MEM;
                    we_next    = (cls_v == CLS_WRITE || cls_v == CLS_FILL);
                    // blocks reuse the saved pointer unchecked
                    maddr_next = (cls_v == CLS_READ || cls_v == CLS_WRITE)
                                 ? addr_v : ptr_reg;
                    fc_next    = we_next ? sreg_reg[SEL_DFC][2:0]
                                         : sreg_reg[SEL_SFC][2:0];
                    wd_next    = data_v;
                end
                CLS_CALL: begin
                    // push return counter below current stack
                    req_next   = 1'b1;
                    we_next    = 1'b1;
                    state_next = ST_MEM;
                    sz_next    = SZ_LONG;
                    maddr_next = sreg_reg[sp_sel] - PUSH_STEP;
                    fc_next    = sreg_reg[SEL_SR][SR_SUPER_BIT] ? FC_SUP_DATA
                                                                : FC_USR_DATA;
                    wd_next    = sreg_reg[SEL_RPC];
                end
                CLS_GO: begin
                    // restart at return counter, updated status word
                    npc_next   = sreg_reg[SEL_RPC];
                    pcl_next   = 1'b1;
                    dbg_next   = 1'b0;
                    state_next = ST_PF;
                    tx_next    = tx_reg;
                end
                default: tx_next = RSP_DONE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_RUN;
            cmd_reg   <= 16'h0000;
            idx_reg   <= 3'h0;
            addr_reg  <= 32'h0000_0000;
            data_reg  <= 32'h0000_0000;
            ptr_reg   <= 32'h0000_0000;
            lo_reg    <= 16'h0000;
            tx_reg    <= RSP_NRDY;
            dbg_reg   <= 1'b0;
            req_reg   <= 1'b0;
            we_reg    <= 1'b0;
            maddr_reg <= 32'h0000_0000;
            fc_reg    <= 3'h0;
            sz_reg    <= 2'h0;
            wd_reg    <= 32'h0000_0000;
            pcl_reg   <= 1'b0;
            npc_reg   <= 32'h0000_0000;
            exc_reg   <= 1'b0;
            for (int i = 0; i < 16; i++)
                sreg_reg[i] <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            cmd_reg   <= cmd_next;
            idx_reg   <= idx_next;
            addr_reg  <= addr_next;
            data_reg  <= data_next;
            ptr_reg   <= ptr_next;
            lo_reg    <= lo_next;
            tx_reg    <= tx_next;
            dbg_reg   <= dbg_next;
            req_reg   <= req_next;
            we_reg    <= we_next;
            maddr_reg <= maddr_next;
            fc_reg    <= fc_next;
            sz_reg    <= sz_next;
            wd_reg    <= wd_next;
            pcl_reg   <= pcl_next;
            npc_reg   <= npc_next;
            exc_reg   <= exc_next;
            sreg_reg  <= sreg_next;
        end
    end

    assign tx_word     = tx_reg;
    assign debug_mode  = dbg_reg;
    assign mem_req     = req_reg;
    assign mem_we      = we_reg;
    assign mem_addr    = maddr_reg;
    assign mem_fc      = fc_reg;
    assign mem_size    = sz_reg;
    assign mem_wdata   = wd_reg;
    assign pc_load     = pcl_reg;
    assign new_pc      = npc_reg;
    assign exc_req     = exc_reg;
    assign status_word = sreg_reg[SEL_SR];

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    logic mem_done;
    assign mem_done = state_reg == ST_MEM && mem_ack;
    sequence s_pc_pulse;
        pc_load ##1 !pc_load;
    endsequence

    property p_ill; state_reg == ST_IDLE && rx_valid && cls_v == CLS_ILL |=> tx_word == RSP_ILL; endproperty
    a_ill: assert property (p_ill) else $error("illegal answer missing");
    property p_nrdy; state_reg == ST_MEM |-> tx_word == RSP_NRDY && mem_req; endproperty
    a_nrdy: assert property (p_nrdy) else $error("not-ready missing");
    property p_far; exec_now && cls_v == CLS_SYSREG_WRITE_CMD |=> $stable(sreg_reg[SEL_FAR]); endproperty
    a_far: assert property (p_far) else $error("fault address changed");
    property p_wsr; exec_now && cls_v == CLS_SYSREG_WRITE_CMD |=> tx_word == RSP_DONE ##1 sreg_reg[SEL_SR][31:16] == 16'h0000; endproperty
    a_wsr: assert property (p_wsr) else $error("register write status");
    property p_rerr; mem_done && mem_err && !mem_we |=> tx_word == RSP_ERR && !mem_req; endproperty
    a_rerr: assert property (p_rerr) else $error("read error status");
    property p_wok; mem_done && !mem_err && cls_v inside {CLS_WRITE, CLS_FILL} |=> tx_word == RSP_DONE; endproperty
    a_wok: assert property (p_wok) else $error("write status");
    property p_ptr; mem_done && !mem_err && cls_v != CLS_CALL |=> ptr_reg == $past(mem_addr) + $past(inc_v); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer not advanced");
    property p_cerr; mem_done && mem_err && cls_v == CLS_CALL |=> debug_mode && state_reg == ST_IDLE; endproperty
    a_cerr: assert property (p_cerr) else $error("call fault left debug");
    property p_go; exec_now && cls_v == CLS_GO |=> s_pc_pulse and (new_pc == $past(sreg_reg[SEL_RPC]) && !debug_mode); endproperty
    a_go: assert property (p_go) else $error("resume pc wrong");
    property p_long; mem_done && !mem_err && !mem_we && mem_size == SZ_LONG |=> tx_word[15:0] == $past(mem_rdata[31:16]); endproperty
    a_long: assert property (p_long) else $error("high word not first");
endmodule

`default_nettype wire

// File: bdc_far_model.sv
/*
 * Memory and core model on the far side of the command executor.
 * Assumes one clock, async active-low reset, requests held until ack.
 */
`timescale 1ns/1ps
`default_nettype none

module bdc_far_model (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic        pc_load,
    input  wire logic [31:0] new_pc,
    output logic             mem_ack,
    output logic             mem_err,
    output logic      [31:0] mem_rdata,
    output logic             pf_done,
    output logic             pf_err
);
    logic [3:0] wait_cnt;
    logic [1:0] pf_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Latency grows with address bits 3:2, so some accesses are slow
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_ack   <= 1'b0;
            mem_err   <= 1'b0;
            mem_rdata <= 32'h0;
            wait_cnt  <= 4'h0;
            pf_done   <= 1'b0;
            pf_err    <= 1'b0;
            pf_cnt    <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            pf_done <= 1'b0;
            // Released data bus never repeats the last value
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                if (wait_cnt == {mem_addr[3:2], 2'h0}) begin
                    mem_ack   <= 1'b1;
                    mem_err   <= (mem_addr[31:28] == 4'hE);
                    mem_rdata <= mem_addr ^ 32'hA5A55A5A;
                    wait_cnt  <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
            // Odd restart address faults the first prefetch
            if (pc_load) begin
                pf_cnt <= 2'h3;
            end else if (pf_cnt != 2'h0) begin
                pf_cnt <= pf_cnt - 2'h1;
                if (pf_cnt == 2'h1) begin
                    pf_done <= 1'b1;
                    pf_err  <= new_pc[0];
                end
            end
        end
    end
endmodule

`default_nettype wire

// File: background_debug_command_executor_tb_top.sv
/*
 * Self-checking bench for the command executor with far-side model.
 * Assumes the executor and model compile before it.
 */
`timescale 1ns/1ps
`default_nettype none

module background_debug_command_executor_tb_top;
    import bdc_pkg::*;
    logic        sys_clk, arst_n, rx_valid, enter_debug, debug_mode, mem_req, mem_we;
    logic        mem_ack, mem_err, pc_load, pf_done, pf_err, pf_addr_err, exc_req, cap_we;
    logic [15:0] rx_word;
    logic [16:0] tx_word;
    logic [2:0]  mem_fc, cap_fc;
    logic [1:0]  mem_size, cap_size;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, new_pc, status_word, cap_addr, cap_wdata, a, d;
    int          fail_count, n_checks;

    assign pf_addr_err = pf_err;
    bdc_executor bdc_executor_inst (.*);
    bdc_far_model bdc_far_model_inst (.*);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic [15:0] w);
        @(posedge sys_clk);
        #1 rx_valid = 1'b1;
        rx_word = w;
        @(posedge sys_clk);
        #1 rx_valid = 1'b0;
        rx_word = ~w;
    endtask

    task automatic send3(input logic [15:0] c, input logic [31:0] v);
        send(c);
        send(v[31:16]);
        send(v[15:0]);
    endtask

    task automatic send_data(input int s, input logic [31:0] v);
        if (s == 2) send(v[31:16]);
        send(s == 0 ? {8'h00, v[7:0]} : v[15:0]);
    endtask

    task automatic wait_mem;
        cap_addr = 32'hFFFFFFFF;
        for (int i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            if (mem_ack === 1'b1) begin
                {cap_we, cap_fc, cap_size} = {mem_we, mem_fc, mem_size};
                {cap_addr, cap_wdata} = {mem_addr, mem_wdata};
                break;
            end
        end
        #1;
    endtask

    task automatic wait_pc(input logic [31:0] exp);
        for (int i = 0; i < 20 && pc_load !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check(new_pc, exp);
        check(debug_mode, 1'b0);
    endtask

    function automatic logic [31:0] step(input int s);
        return s == 0 ? 32'h1 : (s == 1 ? 32'h2 : 32'h4);
    endfunction

    function automatic logic [31:0] mask(input int s);
        return s == 0 ? 32'hFF : (s == 1 ? 32'hFFFF : 32'hFFFFFFFF);
    endfunction

    // Read result: long comes high word first, rest zero-extended
    task automatic chk_rd(input logic [31:0] ad, input int s);
        logic [31:0] r;
        r = (ad ^ 32'hA5A55A5A) & mask(s);
        check(cap_addr, ad);
        check({cap_we, cap_fc, cap_size}, {1'b0, 3'h3, 2'(s)});
        check(tx_word, {1'b0, (s == 2) ? r[31:16] : r[15:0]});
        if (s == 2) begin
            send(OPC_NOP);
            check(tx_word, {1'b0, r[15:0]});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        a = $urandom(32'hd9a7083e);
        {arst_n, rx_valid, rx_word, enter_debug, fail_count, n_checks} = '0;
        repeat (3) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        check(tx_word, RSP_NRDY);
        check(debug_mode, 1'b0);
        enter_debug = 1'b1;
        @(posedge sys_clk);
        #1 enter_debug = 1'b0;
        check(debug_mode, 1'b1);
        send3({OPC_SYSREG_WRITE_CMD, SEL_SR}, 32'h5A5A2000);
        check(tx_word, RSP_DONE);
        check(status_word, 32'h2000);
        send3({OPC_SYSREG_WRITE_CMD, SEL_SFC}, 32'h12340003);
        send3({OPC_SYSREG_WRITE_CMD, SEL_DFC}, 32'h43210006);
        send3({OPC_SYSREG_WRITE_CMD, SEL_SSP}, 32'h1000);
        send3({OPC_SYSREG_WRITE_CMD, SEL_RPC}, 32'h3000);
        send3({OPC_SYSREG_WRITE_CMD, SEL_FAR}, 32'h77);
        check(tx_word, RSP_DONE);
        for (int s = 0; s < 3; s++) begin
            a = $urandom & 32'h0FFFFFFF;
            d = $urandom;
            send3({OPC_READ, 2'(s), 6'h0}, a);
            wait_mem;
            chk_rd(a, s);
            send(OPC_NOP);
            send({OPC_DUMP, 2'(s), 6'h0});
            wait_mem;
            chk_rd(a + step(s), s);
            send3({OPC_WRITE, 2'(s), 6'h0}, a);
            send_data(s, d);
            wait_mem;
            check({cap_addr, cap_we, cap_fc, cap_size}, {a, 1'b1, 3'h6, 2'(s)});
            check(cap_wdata & mask(s), d & mask(s));
            check(tx_word, RSP_DONE);
            send(OPC_NOP);
            send({OPC_FILL, 2'(s), 6'h0});
            send_data(s, ~d);
            wait_mem;
            check(cap_addr, a + step(s));
            check(cap_wdata & mask(s), ~d & mask(s));
            check(tx_word, RSP_DONE);
        end
        send3({OPC_READ, SZ_WORD, 6'h0}, 32'hCC);
        send(16'h7777);
        check(tx_word, RSP_NRDY);
        wait_mem;
        chk_rd(32'hCC, 1);
        send3({OPC_READ, SZ_WORD, 6'h0}, 32'hE0000000);
        wait_mem;
        check(tx_word, RSP_ERR);
        send3({OPC_WRITE, SZ_WORD, 6'h0}, 32'hE0000000);
        send(16'h1234);
        wait_mem;
        check(tx_word, RSP_ERR);
        send({OPC_FILL, SZ_WORD, 6'h0});
        send(16'h4321);
        wait_mem;
        check(tx_word, RSP_ERR);
        send(16'h7777);
        check(tx_word, RSP_ILL);
        send3(OPC_CALL, 32'h4000);
        wait_mem;
        check({cap_addr, cap_we, cap_fc}, {32'hFFC, 1'b1, FC_SUP_DATA});
        check(cap_wdata, 32'h3000);
        wait_pc(32'h4000);
        // Hold the halt request until the prefetch wait is over
        enter_debug = 1'b1;
        for (int i = 0; i < 20 && debug_mode !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        enter_debug = 1'b0;
        send3({OPC_SYSREG_WRITE_CMD, SEL_SSP}, 32'hE0000010);
        send3(OPC_CALL, 32'h4000);
        wait_mem;
        check(tx_word, RSP_ERR);
        check(debug_mode, 1'b1);
        send3({OPC_SYSREG_WRITE_CMD, SEL_RPC}, 32'h5001);
        send(OPC_GO);
        wait_pc(32'h5001);
        for (int i = 0; i < 20 && exc_req !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check(exc_req, 1'b1);
        finish_test;
    end

    initial begin
        #100000;
        fail_count++;
        finish_test;
    end
endmodule

`default_nettype wire
